// [include/uhrc_pkg.sv]
package uhrc_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] CMD_OFFSET = 8'h00;
    localparam logic [7:0] STS_OFFSET = 8'h04;
    localparam logic [7:0] PORT_OFFSET = 8'h08;
    localparam logic [7:0] CAP_OFFSET = 8'h20;
    // ****************************************
    // field positions
    // ****************************************
    localparam int RUN_STOP_BIT = 0;
    localparam int SOFT_RESET_BIT = 1;
    localparam int HALTED_BIT = 12;
    localparam int SYS_ERR_BIT = 4;
    localparam int PORT_OWNER_BIT = 0;
    localparam int PORT_TEST_LSB = 4;
    localparam int PORT_COUNT = 6;
    // ****************************************
    // reset values and timing
    // ****************************************
    localparam logic [31:0] CMD_RESET = 32'h0000_0000;
    localparam logic [7:0] PORT_RESET = 8'h01;
    localparam int RESET_TIME_NS = 100;
    localparam int CLOCK_PERIOD_NS = 5;
    localparam logic [7:0] RESET_CYCLES = 8'((RESET_TIME_NS + CLOCK_PERIOD_NS - 1)
        / CLOCK_PERIOD_NS);
    typedef enum logic [1:0] {UHRC_STOPPED, UHRC_RUNNING, UHRC_HALTING, UHRC_RESETTING}
        uhrc_state_t;
endpackage

// [logic/uhrc_top.sv]
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/100ps
module uhrc_top (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic txn_busy_i,
    input wire logic mem_read_done_i,
    input wire logic mem_read_ok_i,
    input wire logic [31:0] cap_value_i,
    output logic schedule_run_o,
    output logic txn_abort_o,
    output logic soft_reset_o,
    output logic bus_reset_drive_o,
    output logic [5:0] port_companion_o,
    output logic [5:0] port_test_active_o
);
    // ****************************************
    // bus decode
    // ****************************************
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    logic access;
    logic wr;
    assign access = psel_i && penable_i;
    assign wr = access && pwrite_i;

    // ****************************************
    // run/stop and reset state
    // ****************************************
    uhrc_pkg::uhrc_state_t state_reg, state_next;
    logic run_reg, run_next;
    logic halted_reg, halted_next;
    logic rst_reg, rst_next;
    logic sys_err_reg, sys_err_next;
    logic abort_reg, abort_next;
    logic [7:0] rcnt_reg, rcnt_next;
    logic [7:0] cap_reg, cap_next;
    logic [7:0] port_reg [uhrc_pkg::PORT_COUNT];
    logic [7:0] port_next [uhrc_pkg::PORT_COUNT];
    logic [31:0] rdata_reg, rdata_next;
    logic rdy_reg, rdy_next;
    logic err_reg, err_next;
    logic sched_reg, sched_next;
    logic [5:0] comp_reg, comp_next;
    logic [5:0] test_reg, test_next;
    logic cap_hit;
    logic mem_fail;
    logic cmd_wr;
    logic sts_wr;
    logic port_sel;
    logic [2:0] port_idx;

    assign mem_fail = mem_read_done_i && !mem_read_ok_i;
    assign cmd_wr = wr && hit(paddr_i, uhrc_pkg::CMD_OFFSET);
    assign sts_wr = wr && hit(paddr_i, uhrc_pkg::STS_OFFSET);
    assign cap_hit = hit(paddr_i, uhrc_pkg::CAP_OFFSET);
    assign port_sel = paddr_i >= uhrc_pkg::PORT_OFFSET
        && paddr_i < uhrc_pkg::PORT_OFFSET + 8'(4 * uhrc_pkg::PORT_COUNT)
        && paddr_i[1:0] == 2'b00;
    assign port_idx = 3'((paddr_i - uhrc_pkg::PORT_OFFSET) >> 2);

    always_comb begin
        state_next = state_reg;
        run_next = run_reg;
        halted_next = halted_reg;
        rst_next = rst_reg;
        sys_err_next = sys_err_reg;
        abort_next = 1'b0;
        rcnt_next = rcnt_reg;
        cap_next = cap_reg;
        for (int i = 0; i < uhrc_pkg::PORT_COUNT; i++) begin
            port_next[i] = port_reg[i];
        end
        unique case (state_reg)
            uhrc_pkg::UHRC_STOPPED: begin
                halted_next = 1'b1;
                if (run_reg) begin
                    halted_next = 1'b0;
                    state_next = uhrc_pkg::UHRC_RUNNING;
                end
            end
            uhrc_pkg::UHRC_RUNNING: begin
                if (!run_reg) begin
                    state_next = uhrc_pkg::UHRC_HALTING;
                end
            end
            uhrc_pkg::UHRC_HALTING: begin
                if (!txn_busy_i) begin
                    halted_next = 1'b1;
                    state_next = uhrc_pkg::UHRC_STOPPED;
                end
            end
            uhrc_pkg::UHRC_RESETTING: begin
                if (rcnt_reg == 8'h00) begin
                    rst_next = 1'b0;
                    run_next = 1'b0;
                    halted_next = 1'b1;
                    state_next = uhrc_pkg::UHRC_STOPPED;
                end else begin
                    rcnt_next = rcnt_reg - 8'h01;
                end
            end
        endcase
        // a command write outside a running reset acts on the written value at once
        if (cmd_wr && state_reg != uhrc_pkg::UHRC_RESETTING) begin
            run_next = pwdata_i[uhrc_pkg::RUN_STOP_BIT];
            // a restart caught mid-halt must drop halted too, or run and halted meet
            if (pwdata_i[uhrc_pkg::RUN_STOP_BIT]) begin
                halted_next = 1'b0;
            end
        end
        if (sts_wr && pwdata_i[uhrc_pkg::SYS_ERR_BIT]) begin
            sys_err_next = 1'b0;
        end
        if (port_sel && wr && state_reg != uhrc_pkg::UHRC_RESETTING) begin
            port_next[port_idx] = pwdata_i[7:0];
        end
        // hardware clear of run outranks the software write only while run is already set
        if (mem_fail && run_reg) begin
            run_next = 1'b0;
        end
        if (mem_fail) begin
            sys_err_next = 1'b1;
        end
        // starting reset outranks everything; a reset write during a running reset is ignored
        if (cmd_wr && pwdata_i[uhrc_pkg::SOFT_RESET_BIT]
            && state_reg != uhrc_pkg::UHRC_RESETTING) begin
            state_next = uhrc_pkg::UHRC_RESETTING;
            rst_next = 1'b1;
            abort_next = 1'b1;
            run_next = 1'b0;
            halted_next = 1'b1;
            sys_err_next = 1'b0;
            rcnt_next = uhrc_pkg::RESET_CYCLES - 8'h01;
            for (int i = 0; i < uhrc_pkg::PORT_COUNT; i++) begin
                port_next[i] = uhrc_pkg::PORT_RESET;
            end
        end
        // capability contents are latched outside the reset path
        cap_next = cap_value_i[7:0];
        // registered copy so the pin never shows a raw state decode
        sched_next = state_next == uhrc_pkg::UHRC_RUNNING
            || state_next == uhrc_pkg::UHRC_HALTING;
    end

    // ****************************************
    // apb answer
    // ****************************************
    always_comb begin
        rdata_next = 32'h0000_0000;
        rdy_next = 1'b0;
        err_next = 1'b0;
        if (psel_i && !penable_i) begin
            rdy_next = 1'b1;
            if (!pwrite_i) begin
                if (hit(paddr_i, uhrc_pkg::CMD_OFFSET)) begin
                    rdata_next[uhrc_pkg::RUN_STOP_BIT] = run_next;
                    rdata_next[uhrc_pkg::SOFT_RESET_BIT] = rst_next;
                end else if (hit(paddr_i, uhrc_pkg::STS_OFFSET)) begin
                    rdata_next[uhrc_pkg::HALTED_BIT] = halted_next;
                    rdata_next[uhrc_pkg::SYS_ERR_BIT] = sys_err_next;
                end else if (port_sel) begin
                    rdata_next[7:0] = port_next[port_idx];
                end else if (cap_hit) begin
                    rdata_next[7:0] = cap_next;
                end else begin
                    err_next = 1'b1;
                end
            end else if (!hit(paddr_i, uhrc_pkg::CMD_OFFSET)
                && !hit(paddr_i, uhrc_pkg::STS_OFFSET) && !port_sel && !cap_hit) begin
                err_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= uhrc_pkg::UHRC_STOPPED;
            run_reg <= uhrc_pkg::CMD_RESET[uhrc_pkg::RUN_STOP_BIT];
            halted_reg <= 1'b1;
            rst_reg <= 1'b0;
            sys_err_reg <= 1'b0;
            abort_reg <= 1'b0;
            rcnt_reg <= 8'h00;
            cap_reg <= 8'h00;
            for (int i = 0; i < uhrc_pkg::PORT_COUNT; i++) begin
                port_reg[i] <= uhrc_pkg::PORT_RESET;
            end
            rdata_reg <= 32'h0000_0000;
            rdy_reg <= 1'b0;
            err_reg <= 1'b0;
            sched_reg <= 1'b0;
            comp_reg <= {6{uhrc_pkg::PORT_RESET[uhrc_pkg::PORT_OWNER_BIT]}};
            test_reg <= 6'h00;
        end else begin
            state_reg <= state_next;
            run_reg <= run_next;
            halted_reg <= halted_next;
            rst_reg <= rst_next;
            sys_err_reg <= sys_err_next;
            abort_reg <= abort_next;
            rcnt_reg <= rcnt_next;
            cap_reg <= cap_next;
            for (int i = 0; i < uhrc_pkg::PORT_COUNT; i++) begin
                port_reg[i] <= port_next[i];
            end
            rdata_reg <= rdata_next;
            rdy_reg <= rdy_next;
            err_reg <= err_next;
            sched_reg <= sched_next;
            comp_reg <= comp_next;
            test_reg <= test_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign prdata_o = rdata_reg;
    assign pready_o = rdy_reg;
    assign pslverr_o = err_reg;
    assign schedule_run_o = sched_reg;
    assign txn_abort_o = abort_reg;
    assign soft_reset_o = rst_reg;
    assign bus_reset_drive_o = 1'b0;
    genvar g;
    generate
        for (g = 0; g < uhrc_pkg::PORT_COUNT; g++) begin : g_port
            assign comp_next[g] = port_next[g][uhrc_pkg::PORT_OWNER_BIT];
            assign test_next[g] = |port_next[g][uhrc_pkg::PORT_TEST_LSB +: 4];
        end
    endgenerate
    assign port_companion_o = comp_reg;
    assign port_test_active_o = test_reg;

    // ****************************************
    // checks
    // ****************************************
    a_reset_self_clears: assert property (@(posedge clock_i) disable iff (!rstn_i)
        $rose(rst_reg) |-> rst_reg [*8] ##[1:30] !rst_reg)
        else $error("soft reset did not self clear in time");
    a_zero_no_end: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (rst_reg && rcnt_reg > 8'h01) |=> rst_reg)
        else $error("soft reset ended early");
    a_abort_on_reset: assert property (@(posedge clock_i) disable iff (!rstn_i)
        $rose(rst_reg) |-> txn_abort_o)
        else $error("transaction not aborted on soft reset");
    a_ports_released: assert property (@(posedge clock_i) disable iff (!rstn_i)
        rst_reg |-> (&port_companion_o && port_test_active_o == 6'h00))
        else $error("ports not returned during soft reset");
    a_run_halt_never: assert property (@(posedge clock_i) disable iff (!rstn_i)
        !(run_reg && halted_reg))
        else $error("run and halted both set");
    a_mem_fail_stop: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (mem_fail && !(cmd_wr && pwdata_i[uhrc_pkg::SOFT_RESET_BIT])) |=> !run_reg)
        else $error("failed read did not clear run");
    a_halt_after_txn: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (state_reg == uhrc_pkg::UHRC_HALTING && !txn_busy_i && !rst_reg
        && !(cmd_wr && pwdata_i[uhrc_pkg::RUN_STOP_BIT])) |=> halted_reg)
        else $error("halted not set after stop");
    a_halt_waits_txn: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (state_reg == uhrc_pkg::UHRC_HALTING && txn_busy_i && !cmd_wr) |=> !halted_reg)
        else $error("halted before transaction finished");
    a_reset_end_state: assert property (@(posedge clock_i) disable iff (!rstn_i)
        $fell(rst_reg) |-> (!run_reg && halted_reg))
        else $error("controller not stopped after reset");
    a_abort_one_pulse: assert property (@(posedge clock_i) disable iff (!rstn_i)
        txn_abort_o |=> !txn_abort_o)
        else $error("abort pulse longer than one cycle");
    a_run_write_stop: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (cmd_wr && !pwdata_i[uhrc_pkg::RUN_STOP_BIT]
        && state_reg != uhrc_pkg::UHRC_RESETTING) |=> !run_reg)
        else $error("run write of zero not applied");
    a_run_write_go: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (cmd_wr && pwdata_i[uhrc_pkg::RUN_STOP_BIT] && !pwdata_i[uhrc_pkg::SOFT_RESET_BIT]
        && state_reg != uhrc_pkg::UHRC_RESETTING && !mem_fail) |=> run_reg)
        else $error("run write of one not applied");
    a_sched_follows: assert property (@(posedge clock_i) disable iff (!rstn_i)
        state_reg == uhrc_pkg::UHRC_RUNNING |-> schedule_run_o)
        else $error("schedule stopped while running");
    a_stop_no_sched: assert property (@(posedge clock_i) disable iff (!rstn_i)
        state_reg == uhrc_pkg::UHRC_STOPPED |-> !schedule_run_o)
        else $error("schedule active while stopped");
    a_active_not_halted: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (state_reg == uhrc_pkg::UHRC_RUNNING
        || state_reg == uhrc_pkg::UHRC_HALTING) |-> !halted_reg)
        else $error("halted set while still executing");
    a_reset_held_stop: assert property (@(posedge clock_i) disable iff (!rstn_i)
        rst_reg |-> (!run_reg && halted_reg))
        else $error("controller not stopped during reset");
    a_reset_entry: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (cmd_wr && pwdata_i[uhrc_pkg::SOFT_RESET_BIT]
        && state_reg != uhrc_pkg::UHRC_RESETTING)
        |=> (rst_reg && rcnt_reg == uhrc_pkg::RESET_CYCLES - 8'h01))
        else $error("soft reset not started");
    a_reset_count_down: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (state_reg == uhrc_pkg::UHRC_RESETTING && rcnt_reg != 8'h00)
        |=> rcnt_reg == $past(rcnt_reg) - 8'h01)
        else $error("reset counter skipped");
    a_unmapped_err: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (psel_i && !penable_i && !hit(paddr_i, uhrc_pkg::CMD_OFFSET)
        && !hit(paddr_i, uhrc_pkg::STS_OFFSET) && !port_sel && !cap_hit)
        |=> (pslverr_o && pready_o))
        else $error("unmapped access not refused");
    a_sys_err_set: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (mem_fail && !(cmd_wr && pwdata_i[uhrc_pkg::SOFT_RESET_BIT]
        && state_reg != uhrc_pkg::UHRC_RESETTING)) |=> sys_err_reg)
        else $error("failed read did not flag system error");
endmodule // uhrc_top

// [testbench/uhrc_far_model.sv]
`timescale 1ns/100ps
module uhrc_far_model #(
    parameter int TXN_CYCLES = 12
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic txn_go_i,
    input wire logic rd_go_i,
    input wire logic rd_ok_i,
    output logic txn_busy_o,
    output logic mem_read_done_o,
    output logic mem_read_ok_o
);
    int left_reg;
    // status means nothing without done, so it keeps toggling to expose stale sampling
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            left_reg <= 0;
            mem_read_done_o <= 1'h0;
            mem_read_ok_o <= 1'h0;
        end else begin
            left_reg <= txn_go_i ? TXN_CYCLES : (left_reg > 0 ? left_reg - 1 : 0);
            mem_read_done_o <= rd_go_i;
            mem_read_ok_o <= rd_go_i ? rd_ok_i : ~mem_read_ok_o;
        end
    end
    assign txn_busy_o = (left_reg > 0);
endmodule // uhrc_far_model

// [testbench/usb2_host_run_reset_control_tb.sv]
`timescale 1ns/100ps
module usb2_host_run_reset_control_tb;
    logic clock_i = 1'h0;
    logic rstn_i = 1'h0;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, busy, rdone, rok, run, abort, srst, bres;
    logic txn_go = 1'h0, rd_go = 1'h0, rd_ok = 1'h1;
    logic [5:0] comp, test;
    int fail_count = 0, total_checks = 0, abort_seen = 0, sr_cycles = 0;
    localparam int HB = uhrc_pkg::HALTED_BIT;

    uhrc_top dut_u (.clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .txn_busy_i(busy), .mem_read_done_i(rdone),
        .mem_read_ok_i(rok), .cap_value_i(32'h5a5a_0f0f), .schedule_run_o(run),
        .txn_abort_o(abort), .soft_reset_o(srst), .bus_reset_drive_o(bres),
        .port_companion_o(comp), .port_test_active_o(test));
    uhrc_far_model far_u (.clock_i(clock_i), .rstn_i(rstn_i), .txn_go_i(txn_go),
        .rd_go_i(rd_go), .rd_ok_i(rd_ok), .txn_busy_o(busy), .mem_read_done_o(rdone),
        .mem_read_ok_o(rok));

    initial begin
        forever #2.5 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        if (abort === 1'h1) abort_seen++;
        if (srst === 1'h1) sr_cycles++;
    end

    // ****************************************
    // shared helpers
    // ****************************************
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic give_up();
        fail_count++;
        close_out();
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // every transfer is held until pready is sampled high, never assumed
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock_i);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'h1;
        do begin
            @(posedge clock_i);
            n++;
        end while (pready !== 1'h1 && n < 50);
        if (pready !== 1'h1) give_up();
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wait_low(input bit pick_reset);
        int n;
        n = 0;
        while ((pick_reset ? srst : busy) !== 1'h0 && n < 60) begin
            @(posedge clock_i);
            n++;
        end
        if ((pick_reset ? srst : busy) !== 1'h0) give_up();
    endtask
    task automatic fire_txn();
        txn_go <= 1'h1;
        @(posedge clock_i);
        txn_go <= 1'h0;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset_values();
        apb(1'h0, uhrc_pkg::CMD_OFFSET, 32'h0000_0000);
        chk(rd, uhrc_pkg::CMD_RESET);
        apb(1'h0, uhrc_pkg::STS_OFFSET, 32'h0000_0000);
        chk(rd[HB], 1'h1);
        chk({comp, test}, 12'hfc0);
        chk(bres, 1'h0);
    endtask
    task automatic t_run_halt();
        apb(1'h1, uhrc_pkg::CMD_OFFSET, 32'h0000_0001);
        apb(1'h0, uhrc_pkg::STS_OFFSET, 32'h0000_0000);
        chk({rd[HB], run}, 2'h1);
        fire_txn();
        apb(1'h1, uhrc_pkg::CMD_OFFSET, 32'h0000_0000);
        apb(1'h0, uhrc_pkg::STS_OFFSET, 32'h0000_0000);
        chk({rd[HB], run}, 2'h1);
        wait_low(1'b0);
        apb(1'h0, uhrc_pkg::STS_OFFSET, 32'h0000_0000);
        chk({rd[HB], run}, 2'h2);
    endtask
    task automatic t_mem_fail();
        apb(1'h1, uhrc_pkg::CMD_OFFSET, 32'h0000_0001);
        rd_ok <= 1'h0;
        rd_go <= 1'h1;
        @(posedge clock_i);
        rd_go <= 1'h0;
        rd_ok <= 1'h1;
        apb(1'h0, uhrc_pkg::CMD_OFFSET, 32'h0000_0000);
        chk(rd[uhrc_pkg::RUN_STOP_BIT], 1'h0);
        apb(1'h0, uhrc_pkg::STS_OFFSET, 32'h0000_0000);
        chk({rd[HB], rd[uhrc_pkg::SYS_ERR_BIT]}, 2'h3);
    endtask
    task automatic t_soft_reset();
        apb(1'h1, uhrc_pkg::PORT_OFFSET, 32'h0000_0050);
        @(posedge clock_i);
        chk({comp[0], test[0]}, 2'h1);
        fire_txn();
        abort_seen = 0;
        sr_cycles = 0;
        apb(1'h1, uhrc_pkg::CMD_OFFSET, 32'h0000_0002);
        apb(1'h1, uhrc_pkg::CMD_OFFSET, 32'h0000_0000);
        apb(1'h0, uhrc_pkg::CMD_OFFSET, 32'h0000_0000);
        chk(rd[uhrc_pkg::SOFT_RESET_BIT], 1'h1);
        wait_low(1'b1);
        chk(sr_cycles, 32'(uhrc_pkg::RESET_CYCLES));
        chk(abort_seen, 32'h0000_0001);
        chk(bres, 1'h0);
        chk(comp, 6'h3f);
        chk(test, 6'h00);
        apb(1'h0, uhrc_pkg::CMD_OFFSET, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'h0, uhrc_pkg::STS_OFFSET, 32'h0000_0000);
        chk({rd[HB], run}, 2'h2);
        apb(1'h0, uhrc_pkg::CAP_OFFSET, 32'h0000_0000);
        chk(rd, 32'h0000_000f);
    endtask
    task automatic t_unmapped();
        apb(1'h0, 8'h40, 32'h0000_0000);
        chk({err, rd[30:0]}, 32'h8000_0000);
    endtask

    initial begin
        repeat (10) @(posedge clock_i);
        rstn_i <= 1'h1;
        t_reset_values();
        t_run_halt();
        t_mem_fail();
        t_soft_reset();
        t_unmapped();
        close_out();
    end
endmodule // usb2_host_run_reset_control_tb
